//--- rtl/wam_map.svh
/*
  Constants of the waveform acquisition memory: point count, termination
  threshold, word and quantizer widths.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef WAM_MAP_SVH
`define WAM_MAP_SVH

// Build option with a fixed waveform length
`define WAM_PTS 512
// Repetitive acquisition may end once this percentage is written
`define WAM_DONE_PCT 99
`define WAM_PCT_FULL 100
// One point is one binary word
`define WAM_WORD_W 16
// Horizontal quantizer output, signed so both off-screen sides show
`define WAM_HPOS_W 11
// Vertical quantizer: 102.4 steps per division, here tenfold
`define WAM_VSTEPS_X10 1024

`endif

//--- rtl/wam_pkg.sv
/*
  Types shared by the waveform acquisition memory and its output buffer.
  Assumes wam_map.svh is on the include path.
*/
`include "wam_map.svh"

package wam_pkg;

  typedef enum logic [1:0] {MODE_RT, MODE_REP, MODE_AVG} wam_mode_t;

  // One quantizer sample, same clock as the controller
  typedef struct packed {
    logic valid;
    logic signed [`WAM_HPOS_W-1:0] hPos;
    logic [`WAM_WORD_W-1:0] vPos;
  } wam_samp_t;

  // One stored point on its way to the display reader
  typedef struct packed {
    logic [`WAM_WORD_W-1:0] value;
    logic last;
  } wam_point_t;

endpackage

//--- rtl/wam_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module wam_buf2 #(
  parameter int W = 17
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  logic [W-1:0] slot0, slot1, next_slot0, next_slot1;
  logic [1:0] fill, next_fill;
  logic take, give;

  assign inReady = (fill != 2'h2);
  assign outValid = (fill != 2'h0);
  assign outData = slot0;
  assign take = inValid & inReady;
  assign give = outValid & outReady;

  always_comb
  begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_fill = fill;
    if (give)
    begin
      next_slot0 = slot1;
    end
    if (take)
    begin
      if (fill == 2'h0 || (fill == 2'h1 && give))
        next_slot0 = inData;
      else
        next_slot1 = inData;
    end
    if (take && !give)
      next_fill = fill + 2'h1;
    else if (give && !take)
      next_fill = fill - 2'h1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slot0 <= '0;
      slot1 <= '0;
      fill <= 2'h0;
    end
    else
    begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      fill <= next_fill;
    end
  end

endmodule // wam_buf2

`default_nettype wire

//--- rtl/wam_acq_ctrl.sv
/*
  Acquisition controller and point memory: real-time, repetitive and
  averaged capture, end-point repair, gap interpolation, readout.
  Assumes quantizer samples, start and stop arrive on core_clk; sweep
  gate and sample clock are pins from another domain.
*/
// Behaviour
// - Real-time, repetitive and averaged modes are selectable.
// - Controller runs and stops the digitizer and drives its mode.
// - Repetitive sample: horizontal value picks index, vertical is stored.
// - Repetitive and averaged modes keep only samples taken while the sweep gate is on.
// - Off-screen samples go to first or last point, marked erroneous.
// - A point sampled again keeps the newest value; averaged mode keeps the mean of old and new.
// - Repetitive capture ends once 99 percent is written and a sweep has ended.
// - Keyboard stop ends acquisition at once in every mode.
// - Real-time stores one vertical sample per sample clock cycle.
// - Real-time memory is circular, holding the latest samples.
// - Unwritten points between valid neighbours are linearly interpolated.
// - Erroneous end points take their adjacent point's value.
// - Unwritten tail points copy the last written value.
// - Stop before any write clears every point to zero.
// - Each point is one 16-bit word, stored in sequence.
// - Points run from zero to count minus one, left to right.
// - Stored format goes to the display unchanged.
// - Vertical quantized at 102.4 steps per division; 512 points.
`timescale 1ns/1ps
`default_nettype none
`include "wam_map.svh"

module wam_acq_ctrl #(
  parameter int PTS = `WAM_PTS,
  parameter int AW = $clog2(PTS)
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic startReq,
  input wire wam_pkg::wam_mode_t modeSel,
  input wire logic stopReq,
  input wire logic sweepGate,
  input wire logic sampleClk,
  input wire wam_pkg::wam_samp_t samp,
  output logic digRun,
  output wam_pkg::wam_mode_t digMode,
  output logic acqDone,
  output logic outValid,
  input wire logic outReady,
  output wam_pkg::wam_point_t outPoint
);

  localparam int WW = `WAM_WORD_W;

  typedef enum logic [2:0] {
    S_IDLE, S_ACQ, S_EDGE, S_SCAN, S_FILL, S_ZERO, S_OUT
  } wam_state_t;

  wam_state_t st, next_st;
  wam_pkg::wam_mode_t mode, next_mode;
  logic [AW:0] idx, next_idx, gapStart, next_gapStart, wrCnt, next_wrCnt;
  logic [AW-1:0] fIdx, next_fIdx, base, next_base;
  logic [WW-1:0] lastVal, next_lastVal, endVal, next_endVal;
  logic gapOpen, next_gapOpen, haveLast, next_haveLast;
  logic sweepSeen, next_sweepSeen, errL, next_errL, errR, next_errR;
  logic run, next_run, done, next_done;
  logic [PTS-1:0] flags, next_flags;
  logic [WW-1:0] mem [PTS];
  logic wEn;
  logic [AW-1:0] wAddr, sAddr;
  logic [WW-1:0] wData;
  logic pushValid, pushReady;
  wam_pkg::wam_point_t pushData;
  logic gateS1, gateS, gatePrev, clkS1, clkS, clkPrev;
  logic gateFall, rtTick, isRt;

  // Pins pass two flops before the edge detectors look at them
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gateS1 <= 1'b0;
      gateS <= 1'b0;
      gatePrev <= 1'b0;
      clkS1 <= 1'b0;
      clkS <= 1'b0;
      clkPrev <= 1'b0;
    end
    else
    begin
      gateS1 <= sweepGate;
      gateS <= gateS1;
      gatePrev <= gateS;
      clkS1 <= sampleClk;
      clkS <= clkS1;
      clkPrev <= clkS;
    end
  end

  assign gateFall = gatePrev & ~gateS;
  assign rtTick = clkS & ~clkPrev;
  assign isRt = (mode == wam_pkg::MODE_RT);

  function automatic logic [AW-1:0] modAdd(input logic [AW-1:0] a,
                                           input logic [AW:0] b);
    int s;
    s = int'(a) + int'(b);
    if (s >= PTS)
      s = s - PTS;
    return s[AW-1:0];
  endfunction

  function automatic logic reached(input logic [AW:0] cnt);
    return int'(cnt) * `WAM_PCT_FULL >= `WAM_DONE_PCT * PTS;
  endfunction

  // Division is costly but only runs one cycle per unwritten point of a gap
  function automatic logic [WW-1:0] interp(input logic [WW-1:0] a,
                                           input logic [WW-1:0] b,
                                           input logic [AW:0] n,
                                           input logic [AW:0] d);
    int q;
    q = (int'($signed(b)) - int'($signed(a))) * int'(n) / int'(d);
    return a + q[WW-1:0];
  endfunction

  function automatic logic [WW-1:0] avg(input logic [WW-1:0] a,
                                        input logic [WW-1:0] b);
    int s;
    s = (int'($signed(a)) + int'($signed(b))) >>> 1;
    return s[WW-1:0];
  endfunction

  // Off-screen positions land on the nearest end point
  assign sAddr = (samp.hPos < 0) ? '0 :
                 (samp.hPos >= PTS) ? AW'(PTS - 1) :
                 samp.hPos[AW-1:0];

  always_comb
  begin
    next_st = st;
    next_mode = mode;
    next_idx = idx;
    next_gapStart = gapStart;
    next_wrCnt = wrCnt;
    next_fIdx = fIdx;
    next_base = base;
    next_lastVal = lastVal;
    next_endVal = endVal;
    next_gapOpen = gapOpen;
    next_haveLast = haveLast;
    next_sweepSeen = sweepSeen;
    next_errL = errL;
    next_errR = errR;
    next_done = done;
    next_flags = flags;
    wEn = 1'b0;
    wAddr = '0;
    wData = '0;
    pushValid = 1'b0;
    pushData = '0;
    unique case (st)
      S_IDLE:
      begin
        if (startReq)
        begin
          next_st = S_ACQ;
          next_mode = modeSel;
          next_flags = '0;
          next_wrCnt = '0;
          next_idx = '0;
          next_base = '0;
          next_sweepSeen = 1'b0;
          next_errL = 1'b0;
          next_errR = 1'b0;
          next_done = 1'b0;
        end
      end
      S_ACQ:
      begin
        if (isRt && rtTick)
        begin
          wEn = 1'b1;
          wAddr = idx[AW-1:0];
          wData = samp.vPos;
          next_idx = {1'b0, modAdd(idx[AW-1:0], (AW+1)'(1))};
        end
        else if (!isRt && samp.valid && gateS)
        begin
          wEn = 1'b1;
          wAddr = sAddr;
          wData = samp.vPos;
          if (mode == wam_pkg::MODE_AVG && flags[sAddr])
            wData = avg(mem[sAddr], samp.vPos);
          if (samp.hPos < 0)
            next_errL = 1'b1;
          if (samp.hPos >= PTS)
            next_errR = 1'b1;
        end
        if (wEn && !flags[wAddr])
        begin
          next_flags[wAddr] = 1'b1;
          next_wrCnt = wrCnt + 1'b1;
        end
        if (gateFall)
          next_sweepSeen = 1'b1;
        if (stopReq
            || (!isRt && sweepSeen && reached(wrCnt))
            || (isRt && gateFall && wrCnt != '0))
        begin
          next_st = S_EDGE;
          // Oldest sample first once the circle has wrapped
          if (isRt && wrCnt == (AW+1)'(PTS))
            next_base = idx[AW-1:0];
        end
      end
      S_EDGE:
      begin
        // Erroneous ends become gaps, so the scan copies the neighbour
        if (errL)
          next_flags[0] = 1'b0;
        if (errR)
          next_flags[PTS-1] = 1'b0;
        next_idx = '0;
        next_gapOpen = 1'b0;
        next_haveLast = 1'b0;
        next_lastVal = '0;
        next_st = (wrCnt == '0) ? S_ZERO : S_SCAN;
      end
      S_SCAN:
      begin
        if (idx == (AW+1)'(PTS))
        begin
          if (gapOpen)
          begin
            next_endVal = lastVal;
            next_fIdx = gapStart[AW-1:0];
            next_st = S_FILL;
          end
          else
          begin
            next_idx = '0;
            next_done = 1'b1;
            next_st = S_OUT;
          end
        end
        else if (flags[idx[AW-1:0]])
        begin
          if (gapOpen)
          begin
            next_endVal = mem[idx[AW-1:0]];
            if (!haveLast)
              next_lastVal = mem[idx[AW-1:0]];
            next_fIdx = gapStart[AW-1:0];
            next_st = S_FILL;
          end
          else
          begin
            next_lastVal = mem[idx[AW-1:0]];
            next_haveLast = 1'b1;
            next_idx = idx + 1'b1;
          end
        end
        else
        begin
          if (!gapOpen)
          begin
            next_gapOpen = 1'b1;
            next_gapStart = idx;
          end
          next_idx = idx + 1'b1;
        end
      end
      S_FILL:
      begin
        wEn = 1'b1;
        wAddr = fIdx;
        wData = interp(lastVal, endVal,
                       {1'b0, fIdx} - gapStart + 1'b1,
                       idx - gapStart + 1'b1);
        next_fIdx = fIdx + 1'b1;
        if ({1'b0, fIdx} + 1'b1 == idx)
        begin
          next_gapOpen = 1'b0;
          next_st = S_SCAN;
        end
      end
      S_ZERO:
      begin
        wEn = 1'b1;
        wAddr = idx[AW-1:0];
        next_idx = idx + 1'b1;
        if (idx == (AW+1)'(PTS - 1))
        begin
          next_idx = '0;
          next_done = 1'b1;
          next_st = S_OUT;
        end
      end
      S_OUT:
      begin
        pushValid = 1'b1;
        pushData.value = mem[modAdd(base, idx)];
        pushData.last = (idx == (AW+1)'(PTS - 1));
        if (pushReady)
        begin
          next_idx = idx + 1'b1;
          if (pushData.last)
            next_st = S_IDLE;
        end
      end
      default:
      begin
        next_st = S_IDLE;
      end
    endcase
    next_run = (next_st == S_ACQ);
  end

  always_ff @(posedge core_clk)
  begin
    if (wEn)
      mem[wAddr] <= wData;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= S_IDLE;
      mode <= wam_pkg::MODE_RT;
      idx <= '0;
      gapStart <= '0;
      wrCnt <= '0;
      fIdx <= '0;
      base <= '0;
      lastVal <= '0;
      endVal <= '0;
      gapOpen <= 1'b0;
      haveLast <= 1'b0;
      sweepSeen <= 1'b0;
      errL <= 1'b0;
      errR <= 1'b0;
      run <= 1'b0;
      done <= 1'b0;
      flags <= '0;
    end
    else
    begin
      st <= next_st;
      mode <= next_mode;
      idx <= next_idx;
      gapStart <= next_gapStart;
      wrCnt <= next_wrCnt;
      fIdx <= next_fIdx;
      base <= next_base;
      lastVal <= next_lastVal;
      endVal <= next_endVal;
      gapOpen <= next_gapOpen;
      haveLast <= next_haveLast;
      sweepSeen <= next_sweepSeen;
      errL <= next_errL;
      errR <= next_errR;
      run <= next_run;
      done <= next_done;
      flags <= next_flags;
    end
  end

  assign digRun = run;
  assign digMode = mode;
  assign acqDone = done;

  // A stalled reader holds the readout index, so no word is lost
  wam_buf2 #(.W($bits(wam_pkg::wam_point_t))) u_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outPoint)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_stop_ends_acq: assert property (st == S_ACQ && stopReq |=> st == S_EDGE)
    else $error("stop did not end acquisition");
  a_gate_only: assert property (st == S_ACQ && !isRt && !gateS |-> !wEn)
    else $error("sample stored outside sweep gate");
  a_edge_clamp: assert property (st == S_ACQ && wEn && !isRt && samp.hPos < 0
                                 |-> wAddr == '0 ##1 errL)
    else $error("left off-screen sample misplaced");
  a_newest_wins: assert property (wEn |=> mem[$past(wAddr)] == $past(wData))
    else $error("newest sample not retained");
  a_rep_term: assert property (st == S_ACQ && !isRt && sweepSeen && reached(wrCnt)
                               |=> st == S_EDGE)
    else $error("repetitive capture did not end");
  a_rt_tick: assert property (st == S_ACQ && isRt && rtTick
                              |-> wEn && wData == samp.vPos ##1
                                  idx[AW-1:0] == modAdd($past(idx[AW-1:0]),
                                                        (AW+1)'(1)))
    else $error("real-time sample not stored in order");
  a_tail_copy: assert property (st == S_FILL && idx == (AW+1)'(PTS)
                                |-> wData == lastVal)
    else $error("tail not copied from last value");
  a_zero_fill: assert property (st == S_EDGE && wrCnt == '0
                                |=> (st == S_ZERO && wData == '0)[*8])
    else $error("empty capture not cleared");
  a_count_flags: assert property (st == S_ACQ
                                  |-> int'(wrCnt) == $countones(flags))
    else $error("written count disagrees with flags");
  a_done_first: assert property (pushValid |-> done ##0 st == S_OUT)
    else $error("readout before done");
  a_run_mode: assert property ($rose(st == S_ACQ)
                               |-> digRun && digMode == $past(modeSel))
    else $error("digitizer not started in chosen mode");

  c_rep_done: cover property (st == S_ACQ && !isRt && reached(wrCnt) ##1 st == S_EDGE);
  c_fill_gap: cover property (st == S_FILL && idx != (AW+1)'(PTS));
  c_zero_stop: cover property (st == S_ZERO);
  c_rt_wrap: cover property (st == S_ACQ && isRt && wrCnt == (AW+1)'(PTS) && rtTick);

endmodule // wam_acq_ctrl

`default_nettype wire

//--- bench/wam_dig_model.sv
/*
  Behavioural model of the digitizer side: sweep gate, real-time sample
  clock and the quantizer sample lines, driven by tasks from the bench.
  Assumes one core_clk domain; all lines change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wam_map.svh"

module wam_dig_model (
  input wire logic core_clk,
  output logic sweepGate,
  output logic sampleClk,
  output var wam_pkg::wam_samp_t samp
);
  initial
  begin
    sweepGate = 1'b0;
    sampleClk = 1'b0;
    samp = '0;
  end

  // Gate is a pin behind a synchroniser, so allow it time to settle
  task automatic gate(input logic g);
    @(posedge core_clk);
    sweepGate <= g;
    repeat (5) @(posedge core_clk);
  endtask

  // One quantizer sample for one cycle; afterwards the lines show the
  // inverse, so a stale value can never pass for a fresh one
  task automatic put(input logic signed [`WAM_HPOS_W-1:0] h, input logic [15:0] v);
    @(posedge core_clk);
    samp <= '{valid: 1'b1, hPos: h, vPos: v};
    @(posedge core_clk);
    samp <= '{valid: 1'b0, hPos: ~h, vPos: ~v};
  endtask

  // One real-time sample clock cycle; vPos is stable well around the edge
  task automatic rt(input logic [15:0] v);
    @(posedge core_clk);
    samp <= '{valid: 1'b1, hPos: '0, vPos: v};
    repeat (3) @(posedge core_clk);
    sampleClk <= 1'b1;
    repeat (4) @(posedge core_clk);
    sampleClk <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // wam_dig_model

`default_nettype wire

//--- bench/testbench.sv
/*
  Self-checking bench of the acquisition controller with 16 points.
  Assumes the digitizer model in wam_dig_model.sv and a 40 MHz core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int PTS = 16;
  logic core_clk;
  logic arst_n;
  logic startReq;
  logic stopReq;
  logic outReady;
  logic sweepGate;
  logic sampleClk;
  logic digRun;
  logic acqDone;
  logic outValid;
  wam_pkg::wam_mode_t modeSel;
  wam_pkg::wam_mode_t digMode;
  wam_pkg::wam_samp_t samp;
  wam_pkg::wam_point_t outPoint;
  int num_errors;
  int compares;
  logic [15:0] expv [PTS];

  wam_acq_ctrl #(.PTS(PTS)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .startReq(startReq), .modeSel(modeSel),
    .stopReq(stopReq), .sweepGate(sweepGate), .sampleClk(sampleClk), .samp(samp),
    .digRun(digRun), .digMode(digMode), .acqDone(acqDone), .outValid(outValid),
    .outReady(outReady), .outPoint(outPoint)
  );

  wam_dig_model dig (
    .core_clk(core_clk), .sweepGate(sweepGate),
    .sampleClk(sampleClk), .samp(samp)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic start(input wam_pkg::wam_mode_t m);
    @(posedge core_clk);
    startReq <= 1'b1;
    modeSel <= m;
    @(posedge core_clk);
    startReq <= 1'b0;
    #1;
    check(digRun, 32'h1);
    check(digMode, m);
    check(acqDone, 32'h0);
  endtask

  task automatic stop;
    @(posedge core_clk);
    stopReq <= 1'b1;
    @(posedge core_clk);
    stopReq <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check(digRun, 32'h0);
  endtask

  // Waits for done, then drains all points with the reader stalling
  task automatic readout;
    int i;
    int cyc;
    i = 0;
    cyc = 0;
    while (acqDone !== 1'b1 && cyc < 4000)
    begin
      @(posedge core_clk);
      cyc++;
    end
    check(acqDone, 32'h1);
    cyc = 0;
    while (i < PTS && cyc < 4000)
    begin
      @(posedge core_clk);
      if (outValid === 1'b1 && outReady === 1'b1)
      begin
        check(outPoint.value, expv[i]);
        check(outPoint.last, i == PTS - 1);
        i++;
      end
      outReady <= (cyc % 3) != 1;
      cyc++;
    end
    @(posedge core_clk);
    outReady <= 1'b0;
    check(i, PTS);
  endtask

  task automatic rep_full;
    start(wam_pkg::MODE_REP);
    dig.gate(1'b1);
    dig.put(11'h004, 16'h1111);
    for (int i = 0; i < PTS; i++)
    begin
      dig.put(11'(i), 16'(16'h0100 + i * 16));
      expv[i] = 16'(16'h0100 + i * 16);
    end
    dig.put(11'h7FD, 16'h7000);
    dig.put(11'(PTS + 4), 16'h7000);
    expv[0] = expv[1];
    expv[PTS-1] = expv[PTS-2];
    repeat (6) @(posedge core_clk);
    #1;
    // Every point is written, but no sweep has ended yet
    check(digRun, 32'h1);
    dig.gate(1'b0);
    #1;
    check(digRun, 32'h0);
    readout();
  endtask

  task automatic rep_gaps;
    start(wam_pkg::MODE_REP);
    dig.put(11'h001, 16'h5555);
    dig.gate(1'b1);
    dig.put(11'h000, 16'h0064);
    for (int k = 2; k < 8; k++)
      dig.put(11'(k), 16'(16'h00C8 + (k - 2) * 8));
    dig.gate(1'b0);
    stop();
    expv[0] = 16'h0064;
    expv[1] = 16'h0096;
    for (int k = 2; k < PTS; k++)
      expv[k] = (k < 8) ? 16'(16'h00C8 + (k - 2) * 8) : 16'h00F0;
    readout();
  endtask

  task automatic avg_empty;
    start(wam_pkg::MODE_AVG);
    repeat (4) @(posedge core_clk);
    stop();
    for (int k = 0; k < PTS; k++)
      expv[k] = 16'h0000;
    readout();
  endtask

  // Second write to a point averages with the first; gaps take that value
  task automatic avg_mix;
    start(wam_pkg::MODE_AVG);
    dig.gate(1'b1);
    dig.put(11'h003, 16'h0100);
    dig.put(11'h003, 16'h0200);
    dig.gate(1'b0);
    stop();
    for (int k = 0; k < PTS; k++)
      expv[k] = 16'h0180;
    readout();
  endtask

  // Reset in mid-acquisition returns every output to idle
  task automatic mid_reset;
    start(wam_pkg::MODE_REP);
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check(digRun, 32'h0);
    check(digMode, wam_pkg::MODE_RT);
    check(acqDone, 32'h0);
    check(outValid, 32'h0);
    @(posedge core_clk);
    arst_n <= 1'b1;
  endtask

  task automatic real_time;
    start(wam_pkg::MODE_RT);
    dig.gate(1'b1);
    for (int k = 1; k <= PTS + 3; k++)
      dig.rt(16'(k));
    dig.gate(1'b0);
    // Wrapped once: oldest kept sample comes out first
    for (int k = 0; k < PTS; k++)
      expv[k] = 16'(k + 4);
    readout();
  endtask

  initial
  begin
    num_errors = 0;
    compares = 0;
    arst_n = 1'b0;
    startReq = 1'b0;
    stopReq = 1'b0;
    outReady = 1'b0;
    modeSel = wam_pkg::MODE_RT;
    repeat (8) @(posedge core_clk);
    #1;
    check(digRun, 32'h0);
    check(digMode, wam_pkg::MODE_RT);
    check(acqDone, 32'h0);
    check(outValid, 32'h0);
    check(outPoint, 32'h0);
    @(posedge core_clk);
    arst_n <= 1'b1;
    rep_full();
    rep_gaps();
    avg_empty();
    avg_mix();
    mid_reset();
    real_time();
    end_of_test();
  end

  // Whole run is under a thousand cycles; this bound only cuts a hang
  initial
  begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
endmodule // testbench

`default_nettype wire
